/* File: rtl/timer_defines.svh */
// constants of the six-channel timer event and request block
// assumes one 100 MHz clock; included by bare name
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADDR_W        7
`define DATA_W        16
`define NUM_CH        6
`define NUM_MATCH     16
// register offsets inside a channel; channel index sits in address bits 6:4
`define OFF_CTRL      4'h0
`define OFF_ENABLE    4'h1
`define OFF_STATUS    4'h2
`define OFF_COUNT     4'h3
`define OFF_MATCH_A   4'h4
`define OFF_MATCH_B   4'h5
`define OFF_MATCH_D   4'h7
// control bits
`define CTRL_RUN      0
`define CTRL_QUAD     1
`define CTRL_CLR_C    2
`define CTRL_CAP_A    3
`define CTRL_CAP_B    4
`define CTRL_BUF_BD   5
// status and enable layout; index order is the fixed in-channel priority
`define FLAG_A        0
`define FLAG_B        1
`define FLAG_C        2
`define FLAG_D        3
`define FLAG_OVF      4
`define FLAG_UNF      5
`define FLAG_DIR      7
`define CTRL_RESET    6'h00
`define ENABLE_RESET  6'h00
`define COUNT_RESET   16'h0000
`define COUNT_MAX     16'hffff
`define MATCH_RESET   16'hffff
`define PRIO_NONE     3'h7
`endif

/* File: rtl/timer_pkg.sv */
// types shared by the timer event and request block
// assumes timer_defines.svh constants for widths
package timer_pkg;
    typedef struct packed {
        logic [15:0] match_req;
        logic [15:0] xfer_req;
        logic [5:0]  ovf_req;
        logic [3:0]  unf_req;
        logic [5:0]  dma_req;
    } req_bundle_t;

    typedef struct packed {
        logic [5:0]       ctrl;
        logic [5:0]       enable;
        logic [5:0]       flags;
        logic             dir;
        logic [15:0]      count;
        logic [3:0][15:0] match;
    } chan_t;

    typedef struct packed {
        chan_t [5:0]     ch;
        logic [15:0]     rdata;
        req_bundle_t     req;
        logic            irq;
        logic [5:0][2:0] top_src;
    } top_state_t;

    typedef struct packed {
        logic b_prev;
    } quad_state_t;
endpackage : timer_pkg

/* File: rtl/quad_edge_decode.sv */
// quadrature mode four decoder for one external clock pin pair
// assumes pins already synchronous to the clock
`timescale 1ns/10ps
module quad_edge_decode (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic phase_a,
    input  wire logic phase_b,
    output logic      step_up,
    output logic      step_down
);
    import timer_pkg::*;
    quad_state_t st_reg;
    quad_state_t st_next;
    logic        b_edge;

    // only B edges count; the A level picks the direction, A edges do nothing
    always_comb begin
        st_next        = st_reg;
        st_next.b_prev = phase_b;
        b_edge         = phase_b ^ st_reg.b_prev;
        step_up        = b_edge & (phase_a == phase_b);
        step_down      = b_edge & (phase_a != phase_b);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : quad_edge_decode

/* File: rtl/source_priority.sv */
// fixed in-channel priority: lowest pending index wins
// purely combinational; caller registers the result
`timescale 1ns/10ps
`include "timer_defines.svh"
module source_priority (
    input  wire logic [5:0] pending,
    output logic      [2:0] top_index
);
    // A, B, C, D, overflow, underflow in that order
    always_comb begin
        top_index = `PRIO_NONE;
        for (int k = 5; k >= 0; k--) begin
            if (pending[k]) begin
                top_index = 3'(k);
            end
        end
    end
endmodule : source_priority

/* File: rtl/timer_event_unit.sv */
// six-channel 16-bit timer: counting, captures, event flags and requests
// assumes a plain strobe register port and synchronous external clock pins
`timescale 1ns/10ps
`include "timer_defines.svh"
module timer_event_unit (
    input  wire logic                 SYS_CLK,
    input  wire logic                 RESETN,
    input  wire logic [6:0]           ADDR,
    input  wire logic [15:0]          WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [15:0]          RDATA,
    input  wire logic                 EXT_CLK_A,
    input  wire logic                 EXT_CLK_B,
    input  wire logic                 EXT_CLK_C,
    input  wire logic                 EXT_CLK_D,
    input  wire logic [15:0]          XFER_ACK,
    input  wire logic [5:0]           DMA_ACK,
    output timer_pkg::req_bundle_t    REQ,
    output logic                      IRQ,
    output logic      [5:0][2:0]      TOP_SOURCE
);
    import timer_pkg::*;

    top_state_t       st_reg;
    top_state_t       st_next;
    logic [1:0]       q_up;
    logic [1:0]       q_down;
    logic [5:0][2:0]  prio_idx;

    // number of match registers: four on channels 0 and 3
    function automatic logic [2:0] num_match(input int c);
        return (c == 0 || c == 3) ? 3'h4 : 3'h2;
    endfunction : num_match

    // underflow and quadrature exist on channels 1, 2, 4, 5
    function automatic logic has_quad(input int c);
        return (c == 1 || c == 2 || c == 4 || c == 5);
    endfunction : has_quad

    // flat index of a channel's first match source
    function automatic logic [3:0] match_base(input int c);
        case (c)
            0:       return 4'h0;
            1:       return 4'h4;
            2:       return 4'h6;
            3:       return 4'h8;
            4:       return 4'hc;
            default: return 4'he;
        endcase
    endfunction : match_base

    // flat index of a channel's underflow request
    function automatic logic [1:0] unf_index(input int c);
        case (c)
            1:       return 2'h0;
            2:       return 2'h1;
            4:       return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : unf_index

    // pin pair A/B feeds channels 1 and 5, pair C/D feeds 2 and 4
    quad_edge_decode u_pair_ab (
        .clk       (SYS_CLK),
        .rst_n     (RESETN),
        .phase_a   (EXT_CLK_A),
        .phase_b   (EXT_CLK_B),
        .step_up   (q_up[0]),
        .step_down (q_down[0])
    );
    quad_edge_decode u_pair_cd (
        .clk       (SYS_CLK),
        .rst_n     (RESETN),
        .phase_a   (EXT_CLK_C),
        .phase_b   (EXT_CLK_D),
        .step_up   (q_up[1]),
        .step_down (q_down[1])
    );

    // priority of the registered pending sources, one cycle behind REQ
    for (genvar g = 0; g < `NUM_CH; g++) begin : g_prio
        source_priority u_prio (
            .pending   (st_reg.ch[g].flags & st_reg.ch[g].enable),
            .top_index (prio_idx[g])
        );
    end

    logic [5:0]       up;
    logic [5:0]       down;
    logic [5:0][3:0]  hit;
    logic [5:0][3:0]  cap;
    logic [2:0]       rch;
    logic [3:0]       roff;
    logic [5:0]       clr;
    logic [5:0]       pend;
    int               mi;

    always_comb begin
        st_next = st_reg;
        up      = '0;
        down    = '0;
        hit     = '0;
        cap     = '0;
        clr     = '0;
        pend    = '0;
        mi      = 0;
        rch     = ADDR[6:4];
        roff    = ADDR[3:0];
        // count steps: internal tick, or B-edge steps in quadrature mode
        for (int c = 0; c < `NUM_CH; c++) begin
            if (st_reg.ch[c].ctrl[`CTRL_RUN]) begin
                if (has_quad(c) && st_reg.ch[c].ctrl[`CTRL_QUAD]) begin
                    up[c]   = (c == 1 || c == 5) ? q_up[0] : q_up[1];
                    down[c] = (c == 1 || c == 5) ? q_down[0] : q_down[1];
                end else begin
                    up[c] = 1'b1;
                end
                // compare matches on registers not used for capture
                for (int k = 0; k < 4; k++) begin
                    if (3'(k) < num_match(c) && st_reg.ch[c].count == st_reg.ch[c].match[k]
                        && !(k == 0 && st_reg.ch[c].ctrl[`CTRL_CAP_A])
                        && !(k == 1 && st_reg.ch[c].ctrl[`CTRL_CAP_B])) begin
                        hit[c][k] = 1'b1;
                    end
                end
            end
        end
        // cross-channel capture triggers
        cap[1][0] = st_reg.ch[1].ctrl[`CTRL_CAP_A] & hit[0][0];
        cap[1][1] = st_reg.ch[1].ctrl[`CTRL_CAP_B] & hit[0][2];
        cap[0][1] = st_reg.ch[0].ctrl[`CTRL_CAP_B] & (up[1] | down[1]);
        // a status read or a transfer acknowledge clears; events below win
        for (int c = 0; c < `NUM_CH; c++) begin
            if (RD && rch == 3'(c) && roff == `OFF_STATUS) begin
                clr = 6'h3f;
                st_next.ch[c].flags = '0;
            end
            for (int k = 0; k < 4; k++) begin
                mi = int'(match_base(c)) + k;
                if (3'(k) < num_match(c) && XFER_ACK[mi]) begin
                    st_next.ch[c].flags[k] = 1'b0;
                end
            end
            if (DMA_ACK[c]) begin
                st_next.ch[c].flags[`FLAG_A] = 1'b0;
            end
            // counter: clear on C match, else step with overflow and underflow
            if (st_reg.ch[c].ctrl[`CTRL_CLR_C] && hit[c][2]) begin
                st_next.ch[c].count = `COUNT_RESET;
            end else if (up[c]) begin
                st_next.ch[c].count = st_reg.ch[c].count + 16'h0001;
                st_next.ch[c].dir   = 1'b1;
                if (st_reg.ch[c].count == `COUNT_MAX) begin
                    st_next.ch[c].flags[`FLAG_OVF] = 1'b1;
                end
            end else if (down[c]) begin
                st_next.ch[c].count = st_reg.ch[c].count - 16'h0001;
                st_next.ch[c].dir   = 1'b0;
                if (st_reg.ch[c].count == `COUNT_RESET && has_quad(c)) begin
                    st_next.ch[c].flags[`FLAG_UNF] = 1'b1;
                end
            end
            // match and capture events set their flags over any clear
            for (int k = 0; k < 4; k++) begin
                if (hit[c][k] || cap[c][k]) begin
                    st_next.ch[c].flags[k] = 1'b1;
                end
                if (cap[c][k]) begin
                    st_next.ch[c].match[k] = st_reg.ch[c].count;
                end
            end
            if (cap[c][1] && st_reg.ch[c].ctrl[`CTRL_BUF_BD] && num_match(c) == 3'h4) begin
                st_next.ch[c].match[3] = st_reg.ch[c].match[1];
            end
            // register writes; a count write wins over stepping
            if (WR && rch == 3'(c)) begin
                if (roff == `OFF_CTRL) begin
                    st_next.ch[c].ctrl = WDATA[5:0];
                end else if (roff == `OFF_ENABLE) begin
                    st_next.ch[c].enable = has_quad(c) ? WDATA[5:0] : {1'b0, WDATA[4:0]};
                end else if (roff == `OFF_COUNT) begin
                    st_next.ch[c].count = WDATA;
                end else if (roff >= `OFF_MATCH_A && roff <= `OFF_MATCH_D
                             && (roff - `OFF_MATCH_A) < 4'(num_match(c))) begin
                    st_next.ch[c].match[roff[1:0]] = WDATA;
                end
            end
        end
        // read data stands only in the cycle after the read strobe
        st_next.rdata = '0;
        if (RD && rch < 3'(`NUM_CH)) begin
            if (roff == `OFF_CTRL) begin
                st_next.rdata = {10'h000, st_reg.ch[rch].ctrl};
            end else if (roff == `OFF_ENABLE) begin
                st_next.rdata = {10'h000, st_reg.ch[rch].enable};
            end else if (roff == `OFF_STATUS) begin
                st_next.rdata = {8'h00, st_reg.ch[rch].dir, 1'b0, st_reg.ch[rch].flags};
            end else if (roff == `OFF_COUNT) begin
                st_next.rdata = st_reg.ch[rch].count;
            end else if (roff >= `OFF_MATCH_A && roff <= `OFF_MATCH_D) begin
                st_next.rdata = st_reg.ch[rch].match[roff[1:0]];
            end
        end
        // requests from next flags and enables, so they track flags exactly
        st_next.req = '0;
        for (int c = 0; c < `NUM_CH; c++) begin
            pend = st_next.ch[c].flags & st_next.ch[c].enable;
            for (int k = 0; k < 4; k++) begin
                if (3'(k) < num_match(c)) begin
                    mi = int'(match_base(c)) + k;
                    st_next.req.match_req[mi] = pend[k];
                    st_next.req.xfer_req[mi]  = pend[k];
                end
            end
            st_next.req.dma_req[c] = pend[`FLAG_A];
            st_next.req.ovf_req[c] = pend[`FLAG_OVF];
            if (has_quad(c)) begin
                st_next.req.unf_req[unf_index(c)] = pend[`FLAG_UNF];
            end
        end
        st_next.irq     = |{st_next.req.match_req, st_next.req.ovf_req, st_next.req.unf_req};
        st_next.top_src = prio_idx;
    end

    // single register stage for the whole state
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= '0;
            for (int c = 0; c < `NUM_CH; c++) begin
                st_reg.ch[c].match <= {4{`MATCH_RESET}};
            end
            st_reg.top_src <= {6{`PRIO_NONE}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA      = st_reg.rdata;
    assign REQ        = st_reg.req;
    assign IRQ        = st_reg.irq;
    assign TOP_SOURCE = st_reg.top_src;

    // helper terms for the checks
    logic ch1_quad_q;
    logic ch1_free_q;
    assign ch1_quad_q = st_reg.ch[1].ctrl[`CTRL_RUN] & st_reg.ch[1].ctrl[`CTRL_QUAD];
    assign ch1_free_q = !(WR && rch == 3'h1) && !(st_reg.ch[1].ctrl[`CTRL_CLR_C] && hit[1][2]);

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_bcap;
        cap[0][1] && st_reg.ch[0].ctrl[`CTRL_BUF_BD];
    endsequence
    sequence s_buffered(logic [15:0] old_b);
        st_reg.ch[0].match[3] == old_b;
    endsequence

    chk_quad_up_step: assert property (
        ch1_quad_q && q_up[0] && ch1_free_q |=>
        st_reg.ch[1].count == $past(st_reg.ch[1].count) + 16'h0001 && st_reg.ch[1].dir)
        else $error("quadrature up step missed");
    chk_a_edge_ignored: assert property (
        ch1_quad_q && !q_up[0] && !q_down[0] && ch1_free_q && !cap[1][0] |=>
        $stable(st_reg.ch[1].count))
        else $error("count moved without a B edge");
    chk_flag_sets_event: assert property (
        hit[0][0] |=> st_reg.ch[0].flags[`FLAG_A])
        else $error("match flag not set");
    chk_req_needs_both: assert property (
        REQ.match_req[0] == (st_reg.ch[0].flags[`FLAG_A] & st_reg.ch[0].enable[`FLAG_A]))
        else $error("request differs from flag and enable");
    chk_req_held_flag: assert property (
        $fell(REQ.ovf_req[2]) |-> !st_reg.ch[2].flags[`FLAG_OVF] || !st_reg.ch[2].enable[`FLAG_OVF])
        else $error("overflow request dropped with flag set");
    chk_set_beats_clear: assert property (
        RD && rch == 3'h0 && roff == `OFF_STATUS && hit[0][1] |=> st_reg.ch[0].flags[`FLAG_B])
        else $error("event lost under clear");
    chk_xfer_match_only: assert property (
        REQ.xfer_req == REQ.match_req)
        else $error("transfer request not a match request");
    chk_dma_a_only: assert property (
        REQ.dma_req[3] == REQ.match_req[8] && REQ.dma_req[1] == REQ.match_req[4])
        else $error("dma request not from register A");
    chk_ovf_wrap: assert property (
        up[4] && st_reg.ch[4].count == `COUNT_MAX && !(WR && rch == 3'h4) |=>
        st_reg.ch[4].flags[`FLAG_OVF] && st_reg.ch[4].count == `COUNT_RESET)
        else $error("overflow not flagged");
    chk_cross_capture: assert property (
        cap[1][0] && !(WR && rch == 3'h1) |=> st_reg.ch[1].match[0] == $past(st_reg.ch[1].count))
        else $error("channel 1 capture wrong");
    chk_buffer_pair: assert property (
        s_bcap and !(WR && rch == 3'h0) |=> s_buffered($past(st_reg.ch[0].match[1])))
        else $error("buffer register not loaded");
endmodule : timer_event_unit

/* File: verif/request_responder.sv */
// model of the far side: transfer and dma controllers answering requests
// assumes level requests from the timer block; acks are one cycle long
`timescale 1ns/10ps
module request_responder #(
    parameter int DELAY = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ack_on,
    input  timer_pkg::req_bundle_t    req,
    output logic      [15:0]          xfer_ack,
    output logic      [5:0]           dma_ack
);
    import timer_pkg::*;
    int   cnt;
    logic busy;

    // only match and register-a requests start a transfer, never ovf or unf
    assign busy = ack_on && (req.xfer_req != '0 || req.dma_req != '0);

    // waits DELAY cycles so slow answers are seen; the ack clears the flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 0;
            xfer_ack <= '0;
            dma_ack  <= '0;
        end else if (busy && cnt == DELAY) begin
            xfer_ack <= req.xfer_req;
            dma_ack  <= req.dma_req;
            cnt      <= 0;
        end else begin
            xfer_ack <= '0;
            dma_ack  <= '0;
            cnt      <= busy ? cnt + 1 : 0;
        end
    end
endmodule : request_responder

/* File: verif/test_timer_event_unit.sv */
// self-checking bench for the six-channel timer event and request block
// assumes the responder model answers transfer requests when switched on
`timescale 1ns/10ps
`include "timer_defines.svh"
module test_timer_event_unit;
    import timer_pkg::*;
    logic            sys_clk;
    logic            resetn;
    logic [6:0]      addr;
    logic [15:0]     wdata;
    logic            wr;
    logic            rd;
    logic [15:0]     rdata;
    logic            pin_a;
    logic            pin_b;
    logic            pin_c;
    logic            pin_d;
    logic [15:0]     xfer_ack;
    logic [5:0]      dma_ack;
    req_bundle_t     req;
    logic            irq;
    logic [5:0][2:0] top_source;
    logic            ack_on;
    int              errors;
    int              n_tests;
    logic [15:0]     rv;
    int              i;

    timer_event_unit timer_event_unit_i (
        .SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EXT_CLK_A(pin_a), .EXT_CLK_B(pin_b), .EXT_CLK_C(pin_c),
        .EXT_CLK_D(pin_d), .XFER_ACK(xfer_ack), .DMA_ACK(dma_ack), .REQ(req), .IRQ(irq),
        .TOP_SOURCE(top_source));

    request_responder #(.DELAY(4)) request_responder_i (
        .clk(sys_clk), .rst_n(resetn), .ack_on(ack_on), .req(req),
        .xfer_ack(xfer_ack), .dma_ack(dma_ack));

    // 100 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report;
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // one-cycle strobes launched right after a rising edge
    task automatic wr_reg(input int ch, input logic [3:0] off, input logic [15:0] d);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= {ch[2:0], off};
        wdata <= d;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input int ch, input logic [3:0] off, output logic [15:0] d);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= {ch[2:0], off};
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // pins move together, then three cycles let the step land
    task automatic qstep(input logic a, input logic b);
        @(posedge sys_clk);
        pin_a <= a;
        pin_b <= b;
        repeat (3) @(posedge sys_clk);
    endtask : qstep

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    // a hang is cut well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        final_report();
    end

    initial begin
        resetn = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; ack_on = 1'b0;
        pin_a = 1'b0; pin_b = 1'b0; pin_c = 1'b0; pin_d = 1'b0; errors = 0; n_tests = 0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        tick();
        chk(16'(irq), 16'h0000, "irq at reset");
        for (i = 0; i < 6; i++) chk(16'(top_source[i]), 16'h0007, "top at reset");
        rd_reg(0, `OFF_MATCH_D, rv); chk(rv, 16'hffff, "match reset");
        rd_reg(3, `OFF_COUNT, rv); chk(rv, 16'h0000, "count reset");
        wr_reg(6, `OFF_MATCH_A, 16'h1234);
        rd_reg(6, `OFF_MATCH_A, rv); chk(rv, 16'h0000, "unmapped channel");
        // ch0 match a with ch1 capturing on it, then the responder clears it
        wr_reg(1, `OFF_COUNT, 16'h1234);
        wr_reg(1, `OFF_CTRL, 16'h0008);
        wr_reg(0, `OFF_MATCH_A, 16'h0020);
        wr_reg(0, `OFF_ENABLE, 16'h0001);
        wr_reg(0, `OFF_CTRL, 16'h0001);
        for (i = 0; i < 100 && req.match_req[0] !== 1'b1; i++) tick();
        chk(req.match_req, 16'h0001, "match req");
        chk(req.xfer_req, 16'h0001, "xfer req");
        chk(16'(req.dma_req), 16'h0001, "dma req");
        chk(16'(irq), 16'h0001, "irq on match");
        tick();
        chk(16'(top_source[0]), 16'h0000, "top ch0");
        wr_reg(0, `OFF_CTRL, 16'h0000);
        rd_reg(1, `OFF_MATCH_A, rv); chk(rv, 16'h1234, "cross capture");
        ack_on <= 1'b1;
        for (i = 0; i < 20 && req.match_req[0] !== 1'b0; i++) tick();
        chk(req.match_req, 16'h0000, "acked");
        chk(16'(irq), 16'h0000, "irq after ack");
        ack_on <= 1'b0;
        // ch4 flag set while disabled: request only once enabled, read clears
        wr_reg(4, `OFF_MATCH_A, 16'h0008);
        wr_reg(4, `OFF_CTRL, 16'h0001);
        repeat (20) tick();
        chk(req.match_req, 16'h0000, "masked flag");
        wr_reg(4, `OFF_CTRL, 16'h0000);
        wr_reg(4, `OFF_ENABLE, 16'h0001);
        tick();
        chk(req.match_req, 16'h1000, "late enable");
        chk(16'(req.dma_req), 16'h0010, "dma ch4");
        rd_reg(4, `OFF_STATUS, rv); chk(rv & 16'h003f, 16'h0001, "status ch4");
        tick();
        chk(req.match_req, 16'h0000, "read clears");
        // ch3 overflow followed by match a: priority moves to a
        wr_reg(3, `OFF_COUNT, 16'hfff0);
        wr_reg(3, `OFF_MATCH_A, 16'h0004);
        wr_reg(3, `OFF_ENABLE, 16'h0011);
        wr_reg(3, `OFF_CTRL, 16'h0001);
        for (i = 0; i < 100 && req.ovf_req[3] !== 1'b1; i++) tick();
        chk(16'(req.ovf_req), 16'h0008, "ovf req");
        chk(req.xfer_req, 16'h0000, "ovf no xfer");
        chk(16'(req.dma_req), 16'h0000, "ovf no dma");
        tick();
        chk(16'(top_source[3]), 16'h0004, "top ovf");
        repeat (8) tick();
        chk(req.match_req, 16'h0100, "ch3 match");
        chk(16'(top_source[3]), 16'h0000, "top a over ovf");
        wr_reg(3, `OFF_CTRL, 16'h0000);
        // b to d still hold ffff from reset, so the pass through ffff flags them too
        rd_reg(3, `OFF_STATUS, rv); chk(rv & 16'h003f, 16'h001f, "status ch3");
        // quadrature on ch1 and ch5 from pins a/b, ch2 on still pins c/d
        wr_reg(0, `OFF_COUNT, 16'h0055);
        wr_reg(0, `OFF_CTRL, 16'h0030);
        wr_reg(1, `OFF_COUNT, 16'h0000);
        wr_reg(1, `OFF_ENABLE, 16'h0020);
        wr_reg(1, `OFF_CTRL, 16'h0003);
        wr_reg(5, `OFF_CTRL, 16'h0003);
        wr_reg(2, `OFF_CTRL, 16'h0003);
        qstep(1'b1, 1'b0);
        qstep(1'b1, 1'b1);
        qstep(1'b0, 1'b1);
        qstep(1'b0, 1'b0);
        rd_reg(1, `OFF_COUNT, rv); chk(rv, 16'h0002, "quad up");
        rd_reg(5, `OFF_COUNT, rv); chk(rv, 16'h0002, "ch5 pins");
        rd_reg(2, `OFF_COUNT, rv); chk(rv, 16'h0000, "ch2 pins");
        rd_reg(1, `OFF_STATUS, rv); chk(rv & 16'h0080, 16'h0080, "dir up");
        rd_reg(0, `OFF_MATCH_B, rv); chk(rv, 16'h0055, "step capture");
        rd_reg(0, `OFF_MATCH_D, rv); chk(rv, 16'h0055, "buffer b to d");
        qstep(1'b0, 1'b1);
        qstep(1'b1, 1'b1);
        qstep(1'b1, 1'b0);
        qstep(1'b0, 1'b0);
        qstep(1'b0, 1'b1);
        #1;
        chk(16'(req.unf_req), 16'h0001, "unf req");
        chk(16'(req.ovf_req), 16'h0000, "no ovf down");
        chk(req.xfer_req, 16'h0000, "unf no xfer");
        chk(16'(irq), 16'h0001, "irq on unf");
        rd_reg(1, `OFF_COUNT, rv); chk(rv, 16'hffff, "quad down");
        rd_reg(1, `OFF_STATUS, rv); chk(rv & 16'h00a0, 16'h0020, "unf dir down");
        final_report();
    end
endmodule : test_timer_event_unit
